// File: rtl/pdc_pkg.sv
package pdc_pkg;

  // ****************************************************************
  // bus geometry
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int LFV_W  = 3;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_STEP_UPPER = 8'h15;
  localparam logic [ADDR_W-1:0] OFS_RSVD_A     = 8'h16;
  localparam logic [ADDR_W-1:0] OFS_RSVD_B     = 8'h17;
  localparam logic [ADDR_W-1:0] OFS_SYNTH_CTRL = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_SYNTH_DIV  = 8'h19;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [DATA_W-1:0] RST_STEP_UPPER = 16'h0000;
  localparam logic [DATA_W-1:0] RST_RSVD       = 16'h0000;
  localparam logic [DATA_W-1:0] RST_SYNTH_CTRL = 16'h2808;
  localparam logic [DATA_W-1:0] RST_SYNTH_DIV  = 16'h0440;
  localparam logic [DATA_W-1:0] DATA_ZERO      = 16'h0000;

  // ****************************************************************
  // field positions, synth_control
  // ****************************************************************
  localparam int CTL_CLAMP_BIT = 12;
  localparam int CTL_NSYNC_BIT = 11;
  localparam int CTL_RUN_BIT   = 10;
  localparam int CTL_PUMP_HI   = 7;
  localparam int CTL_PUMP_LO   = 6;
  localparam int CTL_PRE_HI    = 5;
  localparam int CTL_PRE_LO    = 3;
  localparam int CTL_LFV_HI    = 2;

  // ****************************************************************
  // field positions, synth_dividers
  // ****************************************************************
  localparam int DIV_M_HI    = 15;
  localparam int DIV_M_LO    = 8;
  localparam int DIV_N_HI    = 7;
  localparam int DIV_N_LO    = 4;
  localparam int DIV_BIAS_HI = 3;
  localparam int DIV_BIAS_LO = 2;

  // prescaler ratio of eight, given for code zero
  localparam logic [3:0] PRE_DIV_MAX = 4'h8;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    PDC_PUMP_NONE   = 2'b00,
    PDC_PUMP_SINGLE = 2'b01,
    PDC_PUMP_UNUSED = 2'b10,
    PDC_PUMP_DUAL   = 2'b11
  } pdc_pump_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } pdc_bus_req_t;

endpackage

// File: rtl/pdc_synth_regs.sv
// Decided for this implementation: the plain strobed port.
`timescale 1ns/100ps
module pdc_synth_regs (
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  input  wire pdc_pkg::pdc_bus_req_t   busReq,
  output logic [pdc_pkg::DATA_W-1:0]   busRdata,
  input  wire logic                    syncIn,
  input  wire logic [pdc_pkg::LFV_W-1:0] loopFilterVolt,
  output logic [pdc_pkg::DATA_W-1:0]   stepUpper,
  output logic                         loopFilterClamp,
  output logic                         pllRestart,
  output logic                         nDivSyncPulse,
  output logic                         pllRun,
  output logic                         pllBypass,
  output pdc_pkg::pdc_pump_t           chargePumpSelect,
  output logic [3:0]                   prescaleDiv,
  output logic [8:0]                   mDivide,
  output logic [4:0]                   nDivide,
  output logic [1:0]                   vcoBiasTune
);

  // ****************************************************************
  // decode functions, shared with the checks below except decodeN
  // ****************************************************************

  // unused pump code drives no pump, the safe choice
  function automatic pdc_pkg::pdc_pump_t decodePump(input logic [1:0] code);
    pdc_pkg::pdc_pump_t res;
    res = pdc_pkg::PDC_PUMP_NONE;
    case (code)
      2'b01:   res = pdc_pkg::PDC_PUMP_SINGLE;
      2'b11:   res = pdc_pkg::PDC_PUMP_DUAL;
      default: res = pdc_pkg::PDC_PUMP_NONE;
    endcase
    return res;
  endfunction

  // code zero means the largest ratio, eight
  function automatic logic [3:0] decodePre(input logic [2:0] code);
    return (code == 3'h0) ? pdc_pkg::PRE_DIV_MAX : {1'b0, code};
  endfunction

  // doubled mode shifts the low seven bits up by one
  function automatic logic [8:0] decodeM(input logic [7:0] code);
    return code[7] ? {1'b0, code[6:0], 1'b0} : {2'b00, code[6:0]};
  endfunction

  function automatic logic [4:0] decodeN(input logic [3:0] code);
    return {1'b0, code} + 5'h01;
  endfunction

  // ****************************************************************
  // registers and synchronisers
  // ****************************************************************
  logic [pdc_pkg::DATA_W-1:0] stepUpper_ff;
  logic [pdc_pkg::DATA_W-1:0] rsvdA_ff;
  logic [pdc_pkg::DATA_W-1:0] rsvdB_ff;
  logic [pdc_pkg::DATA_W-1:0] ctrl_ff;
  logic [pdc_pkg::DATA_W-1:0] div_ff;
  logic [pdc_pkg::DATA_W-1:0] rdata_ff;
  logic                       restart_ff;
  logic                       syncS1_ff;
  logic                       syncS2_ff;
  logic                       syncS3_ff;
  logic                       syncLvl_ff;
  logic                       syncPulse_ff;
  logic [pdc_pkg::LFV_W-1:0]  lfvS1_ff;
  logic [pdc_pkg::LFV_W-1:0]  lfvS2_ff;
  logic [pdc_pkg::LFV_W-1:0]  lfvS3_ff;
  logic [pdc_pkg::LFV_W-1:0]  lfv_ff;
  logic                       run_ff;
  logic                       bypass_ff;
  pdc_pkg::pdc_pump_t         pump_ff;
  logic [3:0]                 pre_ff;
  logic [8:0]                 mDiv_ff;
  logic [4:0]                 nDiv_ff;

  // ****************************************************************
  // address decode
  // ****************************************************************
  wire logic hitStep = busReq.addr == pdc_pkg::OFS_STEP_UPPER;
  wire logic hitRsvA = busReq.addr == pdc_pkg::OFS_RSVD_A;
  wire logic hitRsvB = busReq.addr == pdc_pkg::OFS_RSVD_B;
  wire logic hitCtrl = busReq.addr == pdc_pkg::OFS_SYNTH_CTRL;
  wire logic hitDiv  = busReq.addr == pdc_pkg::OFS_SYNTH_DIV;
  wire logic wrStep  = busReq.wr && hitStep;
  wire logic wrRsvA  = busReq.wr && hitRsvA;
  wire logic wrRsvB  = busReq.wr && hitRsvB;
  wire logic wrCtrl  = busReq.wr && hitCtrl;
  wire logic wrDiv   = busReq.wr && hitDiv;

  // low three control bits are the voltage indicator, never stored
  wire logic [pdc_pkg::DATA_W-1:0] ctrlWrVal = {busReq.wdata[15:3], 3'b000};
  wire logic [pdc_pkg::DATA_W-1:0] ctrlRdVal = {ctrl_ff[15:3], lfv_ff};

  wire logic nxt_restart = wrCtrl && ctrl_ff[pdc_pkg::CTL_CLAMP_BIT]
                           && !busReq.wdata[pdc_pkg::CTL_CLAMP_BIT];

  // unmapped addresses read zero
  wire logic [pdc_pkg::DATA_W-1:0] rdMux =
      hitStep ? stepUpper_ff :
      hitRsvA ? rsvdA_ff     :
      hitRsvB ? rsvdB_ff     :
      hitCtrl ? ctrlRdVal    :
      hitDiv  ? div_ff       : pdc_pkg::DATA_ZERO;
  wire logic [pdc_pkg::DATA_W-1:0] nxt_rdata = busReq.rd ? rdMux : pdc_pkg::DATA_ZERO;

  // sync edge, only on a settled rising level
  wire logic syncSettled  = syncS2_ff == syncS3_ff;
  wire logic nxt_syncLvl  = syncSettled ? syncS3_ff : syncLvl_ff;
  wire logic nxt_syncPuls = ctrl_ff[pdc_pkg::CTL_NSYNC_BIT] && nxt_syncLvl && !syncLvl_ff;

  // voltage code taken only when two stages agree
  wire logic [pdc_pkg::LFV_W-1:0] nxt_lfv = (lfvS2_ff == lfvS3_ff) ? lfvS3_ff : lfv_ff;

  // ****************************************************************
  // software registers
  // ****************************************************************

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stepUpper_ff <= pdc_pkg::RST_STEP_UPPER;
      rsvdA_ff     <= pdc_pkg::RST_RSVD;
      rsvdB_ff     <= pdc_pkg::RST_RSVD;
      ctrl_ff      <= pdc_pkg::RST_SYNTH_CTRL;
      div_ff       <= pdc_pkg::RST_SYNTH_DIV;
    end else begin
      if (wrStep) stepUpper_ff <= busReq.wdata;
      if (wrRsvA) rsvdA_ff <= busReq.wdata;
      if (wrRsvB) rsvdB_ff <= busReq.wdata;
      if (wrCtrl) ctrl_ff <= ctrlWrVal;
      if (wrDiv)  div_ff <= busReq.wdata;
    end
  end

  // read data stands in each cycle after a read strobe cycle, zero otherwise
  always_ff @(posedge clk_sys) begin
    if (rst) rdata_ff <= pdc_pkg::DATA_ZERO;
    else     rdata_ff <= nxt_rdata;
  end

  // ****************************************************************
  // pin synchronisers, three stages each
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      syncS1_ff <= 1'b0;
      syncS2_ff <= 1'b0;
      syncS3_ff <= 1'b0;
      lfvS1_ff  <= '0;
      lfvS2_ff  <= '0;
      lfvS3_ff  <= '0;
    end else begin
      syncS1_ff <= syncIn;
      syncS2_ff <= syncS1_ff;
      syncS3_ff <= syncS2_ff;
      lfvS1_ff  <= loopFilterVolt;
      lfvS2_ff  <= lfvS1_ff;
      lfvS3_ff  <= lfvS2_ff;
    end
  end

  // settled levels and event pulses
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      syncLvl_ff   <= 1'b0;
      syncPulse_ff <= 1'b0;
      lfv_ff       <= '0;
      restart_ff   <= 1'b0;
    end else begin
      syncLvl_ff   <= nxt_syncLvl;
      syncPulse_ff <= nxt_syncPuls;
      lfv_ff       <= nxt_lfv;
      restart_ff   <= nxt_restart;
    end
  end

  // ****************************************************************
  // decoded pll controls, registered so outputs come from flops
  // ****************************************************************

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      run_ff    <= 1'b0;
      bypass_ff <= 1'b1;
      pump_ff   <= pdc_pkg::PDC_PUMP_NONE;
      pre_ff    <= decodePre(pdc_pkg::RST_SYNTH_CTRL[pdc_pkg::CTL_PRE_HI:pdc_pkg::CTL_PRE_LO]);
      mDiv_ff   <= decodeM(pdc_pkg::RST_SYNTH_DIV[pdc_pkg::DIV_M_HI:pdc_pkg::DIV_M_LO]);
      nDiv_ff   <= decodeN(pdc_pkg::RST_SYNTH_DIV[pdc_pkg::DIV_N_HI:pdc_pkg::DIV_N_LO]);
    end else begin
      run_ff    <= ctrl_ff[pdc_pkg::CTL_RUN_BIT];
      bypass_ff <= !ctrl_ff[pdc_pkg::CTL_RUN_BIT];
      pump_ff   <= decodePump(ctrl_ff[pdc_pkg::CTL_PUMP_HI:pdc_pkg::CTL_PUMP_LO]);
      pre_ff    <= decodePre(ctrl_ff[pdc_pkg::CTL_PRE_HI:pdc_pkg::CTL_PRE_LO]);
      mDiv_ff   <= decodeM(div_ff[pdc_pkg::DIV_M_HI:pdc_pkg::DIV_M_LO]);
      nDiv_ff   <= decodeN(div_ff[pdc_pkg::DIV_N_HI:pdc_pkg::DIV_N_LO]);
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign busRdata         = rdata_ff;
  assign stepUpper        = stepUpper_ff;
  // clamp is the stored bit itself
  assign loopFilterClamp  = ctrl_ff[pdc_pkg::CTL_CLAMP_BIT];
  assign pllRestart       = restart_ff;
  assign nDivSyncPulse    = syncPulse_ff;
  assign pllRun           = run_ff;
  assign pllBypass        = bypass_ff;
  assign chargePumpSelect = pump_ff;
  assign prescaleDiv      = pre_ff;
  assign mDivide          = mDiv_ff;
  assign nDivide          = nDiv_ff;
  // bias tuning passes through; software must choose the normal setting
  assign vcoBiasTune      = div_ff[pdc_pkg::DIV_BIAS_HI:pdc_pkg::DIV_BIAS_LO];

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_clearClamp;
    wrCtrl && loopFilterClamp && !busReq.wdata[pdc_pkg::CTL_CLAMP_BIT];
  endsequence

  sequence s_restartOnce;
    pllRestart ##1 !pllRestart;
  endsequence

  property p_stepWrite;
    wrStep |=> stepUpper == $past(busReq.wdata);
  endproperty
  a_stepWrite: assert property (p_stepWrite) else $error("step word not stored");

  property p_stepRead;
    busReq.rd && hitStep && !busReq.wr |=> busRdata == stepUpper;
  endproperty
  a_stepRead: assert property (p_stepRead) else $error("step word read wrong");

  property p_rsvdHold;
    !wrRsvA && !wrRsvB |=> $stable(rsvdA_ff) && $stable(rsvdB_ff);
  endproperty
  a_rsvdHold: assert property (p_rsvdHold) else $error("reserved word changed");

  property p_restart;
    s_clearClamp |=> !loopFilterClamp ##0 s_restartOnce;
  endproperty
  a_restart: assert property (p_restart) else $error("restart pulse missing");

  property p_noSpuriousRestart;
    pllRestart |-> $past(loopFilterClamp) && !loopFilterClamp;
  endproperty
  a_noSpuriousRestart: assert property (p_noSpuriousRestart)
    else $error("restart without clamp release");

  property p_syncGate;
    nDivSyncPulse |-> $past(ctrl_ff[pdc_pkg::CTL_NSYNC_BIT]) ##1 !nDivSyncPulse;
  endproperty
  a_syncGate: assert property (p_syncGate) else $error("sync pulse while disabled");

  property p_bypass;
    wrCtrl |-> ##2 pllRun == $past(busReq.wdata[pdc_pkg::CTL_RUN_BIT], 2)
               && pllBypass == !pllRun;
  endproperty
  a_bypass: assert property (p_bypass) else $error("run or bypass wrong");

  property p_pump;
    wrCtrl |-> ##2 chargePumpSelect
               == decodePump($past(busReq.wdata[pdc_pkg::CTL_PUMP_HI:pdc_pkg::CTL_PUMP_LO], 2));
  endproperty
  a_pump: assert property (p_pump) else $error("pump decode wrong");

  property p_pre;
    prescaleDiv == decodePre($past(ctrl_ff[pdc_pkg::CTL_PRE_HI:pdc_pkg::CTL_PRE_LO]));
  endproperty
  a_pre: assert property (p_pre) else $error("prescaler decode wrong");

  property p_lfvRead;
    busReq.rd && hitCtrl |=> busRdata[pdc_pkg::CTL_LFV_HI:0] == $past(lfv_ff);
  endproperty
  a_lfvRead: assert property (p_lfvRead) else $error("voltage code read wrong");

  property p_mDiv;
    wrDiv |-> ##2 mDivide == decodeM($past(busReq.wdata[pdc_pkg::DIV_M_HI:pdc_pkg::DIV_M_LO], 2));
  endproperty
  a_mDiv: assert property (p_mDiv) else $error("m divider wrong");

  property p_nDiv;
    nDivide == {1'b0, $past(div_ff[pdc_pkg::DIV_N_HI:pdc_pkg::DIV_N_LO])} + 5'h01;
  endproperty
  a_nDiv: assert property (p_nDiv) else $error("n divider wrong");

  property p_divReset;
    @(posedge clk_sys) disable iff (1'b0)
      rst |=> div_ff == pdc_pkg::RST_SYNTH_DIV && ctrl_ff == pdc_pkg::RST_SYNTH_CTRL;
  endproperty
  a_divReset: assert property (p_divReset) else $error("reset value wrong");

  // outputs that follow a stored bit, a settled pin level, reset or the read strobe
  property p_clampFollow;
    wrCtrl |=> loopFilterClamp == $past(busReq.wdata[pdc_pkg::CTL_CLAMP_BIT]);
  endproperty
  a_clampFollow: assert property (p_clampFollow) else $error("clamp bit not stored");

  sequence s_syncRise;
    !syncLvl_ff && syncS2_ff && syncS3_ff;
  endsequence

  property p_syncPulse;
    s_syncRise ##0 ctrl_ff[pdc_pkg::CTL_NSYNC_BIT] |=> nDivSyncPulse;
  endproperty
  a_syncPulse: assert property (p_syncPulse) else $error("sync pulse missing");

  property p_wordReset;
    @(posedge clk_sys) disable iff (1'b0)
      rst |=> stepUpper == pdc_pkg::RST_STEP_UPPER && rsvdA_ff == pdc_pkg::RST_RSVD
              && rsvdB_ff == pdc_pkg::RST_RSVD;
  endproperty
  a_wordReset: assert property (p_wordReset) else $error("word reset value wrong");

  property p_rdIdle;
    !busReq.rd |=> busRdata == pdc_pkg::DATA_ZERO;
  endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data outside read cycle");

endmodule

// File: tb/pdc_synth_regs_bench.sv
`timescale 1ns/100ps
module pdc_synth_regs_bench;

  // ****************************************************************
  // design hookup
  // ****************************************************************
  logic                  clk_sys;
  logic                  rst;
  pdc_pkg::pdc_bus_req_t busReq;
  logic [15:0]           busRdata;
  logic                  syncIn;
  logic [2:0]            loopFilterVolt;
  logic [15:0]           stepUpper;
  logic                  loopFilterClamp;
  logic                  pllRestart;
  logic                  nDivSyncPulse;
  logic                  pllRun;
  logic                  pllBypass;
  pdc_pkg::pdc_pump_t    chargePumpSelect;
  logic [3:0]            prescaleDiv;
  logic [8:0]            mDivide;
  logic [4:0]            nDivide;
  logic [1:0]            vcoBiasTune;
  int                    nErrors;
  int                    totalChecks;

  pdc_synth_regs pdc_synth_regs_inst (
    .clk_sys          (clk_sys),
    .rst              (rst),
    .busReq           (busReq),
    .busRdata         (busRdata),
    .syncIn           (syncIn),
    .loopFilterVolt   (loopFilterVolt),
    .stepUpper        (stepUpper),
    .loopFilterClamp  (loopFilterClamp),
    .pllRestart       (pllRestart),
    .nDivSyncPulse    (nDivSyncPulse),
    .pllRun           (pllRun),
    .pllBypass        (pllBypass),
    .chargePumpSelect (chargePumpSelect),
    .prescaleDiv      (prescaleDiv),
    .mDivide          (mDivide),
    .nDivide          (nDivide),
    .vcoBiasTune      (vcoBiasTune)
  );

  // free-running 100 MHz clock
  always #5 clk_sys = ~clk_sys;

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // returns at the edge that takes the write, so pulses can be seen at once
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    busReq.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rdChk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    busReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    busReq.rd <= 1'b0;
    #1;
    chk(busRdata, exp);
  endtask

  // decoded outputs trail the register by a cycle; wait two to be safe
  task automatic settle();
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic testReset();
    rdChk(8'h15, 16'h0000);
    rdChk(8'h16, 16'h0000);
    rdChk(8'h17, 16'h0000);
    rdChk(8'h18, 16'h2808);
    rdChk(8'h19, 16'h0440);
    rdChk(8'h14, 16'h0000);
    chk(stepUpper, 16'h0000);
    chk(16'(pllRun), 16'h0000);
    chk(16'(pllBypass), 16'h0001);
    chk(16'(prescaleDiv), 16'h0001);
    chk(16'(mDivide), 16'h0004);
    chk(16'(nDivide), 16'h0005);
    chk(16'(chargePumpSelect), 16'h0000);
    chk(16'(vcoBiasTune), 16'h0000);
    chk({14'h0000, loopFilterClamp, pllRestart}, 16'h0000);
    $display("test reset done");
  endtask

  task automatic testStep();
    wr(8'h15, 16'h8001);
    settle();
    chk(stepUpper, 16'h8001);
    rdChk(8'h15, 16'h8001);
    wr(8'h16, 16'hA5A5);
    wr(8'h1A, 16'hFFFF);
    rdChk(8'h16, 16'hA5A5);
    rdChk(8'h1A, 16'h0000);
    rdChk(8'h19, 16'h0440);
    $display("test step done");
  endtask

  task automatic testClamp();
    int cnt;
    wr(8'h18, 16'h3808);
    settle();
    chk(16'(loopFilterClamp), 16'h0001);
    chk(16'(pllRestart), 16'h0000);
    wr(8'h18, 16'h2808);
    #1;
    chk(16'(pllRestart), 16'h0001);
    @(posedge clk_sys);
    #1;
    chk(16'(pllRestart), 16'h0000);
    chk(16'(loopFilterClamp), 16'h0000);
    // clearing an already clear clamp must not restart
    wr(8'h18, 16'h2808);
    cnt = 0;
    for (int i = 0; i < 4; i++) begin
      #1;
      if (pllRestart !== 1'b0) cnt++;
      @(posedge clk_sys);
    end
    chk(16'(cnt), 16'h0000);
    $display("test clamp done");
  endtask

  task automatic testRun();
    wr(8'h18, 16'h2C08);
    settle();
    chk({14'h0000, pllRun, pllBypass}, 16'h0002);
    wr(8'h18, 16'h2808);
    settle();
    chk({14'h0000, pllRun, pllBypass}, 16'h0001);
    $display("test run done");
  endtask

  task automatic testCodes();
    for (int i = 0; i < 4; i++) begin
      wr(8'h18, 16'h2808 | 16'(i << 6));
      settle();
      chk(16'(chargePumpSelect), (i == 2) ? 16'h0000 : 16'(i));
    end
    for (int i = 0; i < 8; i++) begin
      wr(8'h18, 16'h2800 | 16'(i << 3));
      settle();
      chk(16'(prescaleDiv), (i == 0) ? 16'h0008 : 16'(i));
      rdChk(8'h18, 16'h2800 | 16'(i << 3));
    end
    $display("test codes done");
  endtask

  task automatic testDiv();
    logic [7:0]  mTab [4] = '{8'h04, 8'h7F, 8'h84, 8'hFF};
    logic [15:0] mExp [4] = '{16'h0004, 16'h007F, 16'h0008, 16'h00FE};
    logic [15:0] val;
    for (int i = 0; i < 16; i++) begin
      val = {mTab[i % 4], 4'(i), 2'b01, 2'b00};
      wr(8'h19, val);
      settle();
      chk(16'(mDivide), mExp[i % 4]);
      chk(16'(nDivide), 16'(i + 1));
      chk(16'(vcoBiasTune), 16'h0001);
      rdChk(8'h19, val);
    end
    $display("test div done");
  endtask

  task automatic testVolt();
    wr(8'h18, 16'h2807);
    loopFilterVolt <= 3'h5;
    repeat (6) @(posedge clk_sys);
    rdChk(8'h18, 16'h2805);
    @(posedge clk_sys);
    loopFilterVolt <= 3'h2;
    repeat (6) @(posedge clk_sys);
    rdChk(8'h18, 16'h2802);
    $display("test volt done");
  endtask

  task automatic syncPulses(output int cnt);
    cnt = 0;
    @(posedge clk_sys);
    syncIn <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_sys);
      #1;
      if (nDivSyncPulse === 1'b1) cnt++;
    end
    @(posedge clk_sys);
    syncIn <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask

  task automatic testSync();
    int cnt;
    syncPulses(cnt);
    chk(16'(cnt), 16'h0001);
    wr(8'h18, 16'h2000);
    syncPulses(cnt);
    chk(16'(cnt), 16'h0000);
    $display("test sync done");
  endtask

  // a reset in mid-run brings the step, control and divider words back
  task automatic testMidReset();
    wr(8'h19, 16'h8F40);
    wr(8'h15, 16'h1234);
    #1;
    chk(stepUpper, 16'h1234);
    chk(16'(mDivide), 16'h001E);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rdChk(8'h15, 16'h0000);
    rdChk(8'h19, 16'h0440);
    repeat (4) @(posedge clk_sys);
    rdChk(8'h18, 16'h280A);
    chk(16'(mDivide), 16'h0004);
    chk(16'(nDivide), 16'h0005);
    chk({14'h0000, pllRun, pllBypass}, 16'h0001);
    $display("test mid reset done");
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    clk_sys        = 1'b0;
    rst            = 1'b1;
    busReq         = '0;
    syncIn         = 1'b0;
    loopFilterVolt = 3'h0;
    nErrors        = 0;
    totalChecks    = 0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    testReset();
    testStep();
    testClamp();
    testRun();
    testCodes();
    testDiv();
    testVolt();
    testSync();
    testMidReset();
    conclude();
  end

endmodule
